/* verilog/pll_tune_params.svh */
// Overview of operation
// - The block holds a seven-bit oscillator trim code that the tuning engine writes during a search.
// - A three-bit settle select, reset 4, sets the wait after each trim change; larger waits longer.
// - With tuning enabled, a write of zero to the hold bit starts a tuning run.
// - The engine adjusts the trim code itself until the oscillator frequency is centred.
// - The completion flag reads one after a run finishes its last trial bit, or after a run was skipped with tuning disabled.
// - The calibration-run bit, reset one, runs calibration while high and holds it in reset while low.
// - Clearing the calibration-run bit also resets the digital and serial-link clock dividers.
`ifndef PLL_TUNE_PARAMS_SVH
`define PLL_TUNE_PARAMS_SVH
`define OFS_TRIM 8'h59
`define OFS_HOLD 8'h5c
`define OFS_TUNE_CTRL 8'h5d
`define OFS_TUNE_STATE 8'h5e
`define OFS_CAL_RUN 8'h61
`define RST_HOLD 1'b0
`define RST_TUNE_EN 1'b0
`define RST_SETTLE_SEL 3'h4
`define RST_CAL_RUN 1'b1
`define RST_TRIM 7'h00
`define TRIM_START 7'h40
`define TRIM_TOP_BIT 3'h6
`define BIT_HOLD 0
`define BIT_TUNE_EN 0
`define FLD_SETTLE_HI 6
`define FLD_SETTLE_LO 4
`define BIT_DONE 0
`define BIT_CAL_RUN 0
`define FLD_TRIM_HI 6
`define FLD_TRIM_LO 0
`define CLK_PERIOD_NS 40
`define SETTLE_BASE_NS 1000
`define SETTLE_BASE_CYC ((`SETTLE_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_MIN_CYC 8
`endif

/* verilog/pll_tune_pkg.sv */
package pll_tune_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SETTLE = 2'b10
  } tune_state_t;

  typedef struct packed {
    logic [15:0] count;
    logic expired;
  } settle_timer_t;

  typedef struct packed {
    tune_state_t state;
    logic hold;
    logic tune_en;
    logic [2:0] settle_sel;
    logic cal_run;
    logic [6:0] trim;
    logic done;
    logic [2:0] bitpos;
    logic [7:0] rdata;
    logic fast_s1;
    logic fast_s2;
    logic start;
  } tune_ctl_t;
endpackage

/* verilog/settle_timer.sv */
module settle_timer
  import pll_tune_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [15:0] load,
  output logic expired
);
  settle_timer_t s_reg;
  settle_timer_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.expired = 1'b0;
    if (start) begin
      s_next.count = load;
    end else if (s_reg.count != 16'h0000) begin
      s_next.count = s_reg.count - 16'h0001;
      s_next.expired = (s_reg.count == 16'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign expired = s_reg.expired;
endmodule // settle_timer

/* verilog/pll_tune_ctrl.sv */
`include "pll_tune_params.svh"

module pll_tune_ctrl
  import pll_tune_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic vco_fast_pin,
  output logic synth_pll_hold,
  output logic [6:0] oscillator_trim_code,
  output logic oscillator_tune_complete,
  output logic tune_active,
  output logic cal_run,
  output logic cal_logic_reset,
  output logic divider_reset
);
  tune_ctl_t s_reg;
  tune_ctl_t s_next;
  logic tmr_expired;
  logic [15:0] settle_load;
  logic wr_hold;
  logic wr_ctrl;
  logic wr_cal;
  logic wr_trim;
  logic finish;
  logic restart;
  logic abort;
  logic [7:0] word_trim;
  logic [7:0] word_hold;
  logic [7:0] word_ctrl;
  logic [7:0] word_state;
  logic [7:0] word_cal;

  // Each step doubles the settle wait
  assign settle_load = 16'(`SETTLE_BASE_CYC) << s_reg.settle_sel;

  // Timer runs on after an abort; an idle engine ignores its expiry
  settle_timer u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(s_reg.start),
    .load(settle_load),
    .expired(tmr_expired)
  );

  assign wr_hold = reg_wr && (reg_addr == `OFS_HOLD);
  assign wr_ctrl = reg_wr && (reg_addr == `OFS_TUNE_CTRL);
  assign wr_cal = reg_wr && (reg_addr == `OFS_CAL_RUN);
  assign wr_trim = reg_wr && (reg_addr == `OFS_TRIM);
  assign abort = wr_hold && reg_wdata[`BIT_HOLD];
  assign restart = wr_hold && !reg_wdata[`BIT_HOLD] && s_reg.tune_en;
  assign finish = (s_reg.state == ST_SETTLE) && tmr_expired && (s_reg.bitpos == 3'h0) &&
    !restart;

  // Reserved bits are never stored, so they read back as zero
  always_comb begin
    word_trim = 8'h00;
    word_trim[`FLD_TRIM_HI:`FLD_TRIM_LO] = s_reg.trim;
    word_hold = 8'h00;
    word_hold[`BIT_HOLD] = s_reg.hold;
    word_ctrl = 8'h00;
    word_ctrl[`FLD_SETTLE_HI:`FLD_SETTLE_LO] = s_reg.settle_sel;
    word_ctrl[`BIT_TUNE_EN] = s_reg.tune_en;
    word_state = 8'h00;
    word_state[`BIT_DONE] = s_reg.done;
    word_cal = 8'h00;
    word_cal[`BIT_CAL_RUN] = s_reg.cal_run;
  end

  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    // Comparator is asynchronous; only the second stage is read
    s_next.fast_s1 = vco_fast_pin;
    s_next.fast_s2 = s_reg.fast_s1;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_TRIM: s_next.rdata = word_trim;
        `OFS_HOLD: s_next.rdata = word_hold;
        `OFS_TUNE_CTRL: s_next.rdata = word_ctrl;
        `OFS_TUNE_STATE: s_next.rdata = word_state;
        `OFS_CAL_RUN: s_next.rdata = word_cal;
        default: s_next.rdata = 8'h00;
      endcase
    end
    // Any hold write ends a run; a skip must not leave the engine searching
    if (wr_hold) begin
      s_next.hold = reg_wdata[`BIT_HOLD];
      s_next.state = ST_IDLE;
      if (abort) begin
        s_next.done = 1'b0;
      end else if (restart) begin
        s_next.done = 1'b0;
        s_next.state = ST_SETTLE;
        s_next.trim = `TRIM_START;
        s_next.bitpos = `TRIM_TOP_BIT;
        s_next.start = 1'b1;
      end else begin
        s_next.done = 1'b1;
      end
    end
    if (wr_ctrl) begin
      s_next.tune_en = reg_wdata[`BIT_TUNE_EN];
      s_next.settle_sel = reg_wdata[`FLD_SETTLE_HI:`FLD_SETTLE_LO];
    end
    if (wr_cal) begin
      s_next.cal_run = reg_wdata[`BIT_CAL_RUN];
    end
    // Engine owns the code mid-run; a stray write would corrupt the search
    if (wr_trim && s_reg.state == ST_IDLE) begin
      s_next.trim = reg_wdata[`FLD_TRIM_HI:`FLD_TRIM_LO];
    end
    // Successive approximation, one bit per settle period; completion set wins
    // A fresh start overrides a step that falls in the same cycle
    if (s_reg.state == ST_SETTLE && tmr_expired && !restart) begin
      if (s_reg.fast_s2) begin
        s_next.trim[s_reg.bitpos] = 1'b0;
      end
      if (s_reg.bitpos == 3'h0) begin
        s_next.state = ST_IDLE;
        s_next.done = 1'b1;
      end else begin
        s_next.bitpos = s_reg.bitpos - 3'h1;
        s_next.trim[s_reg.bitpos - 3'h1] = 1'b1;
        s_next.start = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.hold <= `RST_HOLD;
      s_reg.tune_en <= `RST_TUNE_EN;
      s_reg.settle_sel <= `RST_SETTLE_SEL;
      s_reg.cal_run <= `RST_CAL_RUN;
      s_reg.trim <= `RST_TRIM;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign synth_pll_hold = s_reg.hold;
  assign oscillator_trim_code = s_reg.trim;
  assign oscillator_tune_complete = s_reg.done;
  assign tune_active = (s_reg.state == ST_SETTLE);
  assign cal_run = s_reg.cal_run;
  assign cal_logic_reset = !s_reg.cal_run;
  assign divider_reset = !s_reg.cal_run;

  // Checks share the core clock and its reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Trim moves only while searching, on a host write or on a new start
  chk_trim_idle_stable: assert property (ce && !tune_active && !wr_trim && !restart |=>
    $stable(oscillator_trim_code)) else $error("trim moved while idle");
  chk_settle_min_wait: assert property (ce && s_reg.start |-> ##1 !tmr_expired [*8])
    else $error("settle wait too short");
  chk_tune_start: assert property (ce && restart |=>
    tune_active && oscillator_trim_code == `TRIM_START && !oscillator_tune_complete)
    else $error("tuning did not start");
  chk_search_end: assert property (ce && finish |=>
    !tune_active && oscillator_tune_complete) else $error("search did not finish");
  chk_skip_done: assert property (ce && wr_hold && !reg_wdata[`BIT_HOLD] && !s_reg.tune_en |=>
    oscillator_tune_complete && !tune_active) else $error("skip did not flag done");
  chk_cal_hold: assert property (ce && wr_cal && !reg_wdata[`BIT_CAL_RUN] |=>
    cal_logic_reset && !cal_run) else $error("calibration not held");
  chk_div_reset: assert property (ce && wr_cal && !reg_wdata[`BIT_CAL_RUN] |=>
    divider_reset) else $error("dividers not reset");
  chk_done_clear: assert property (ce && abort && !finish |=>
    !oscillator_tune_complete && synth_pll_hold) else $error("done not cleared by hold");
  chk_done_low_run: assert property (tune_active |-> !oscillator_tune_complete)
    else $error("done high during run");

  // Register port
  chk_hold_write: assert property (ce && wr_hold |=>
    synth_pll_hold == $past(reg_wdata[`BIT_HOLD])) else $error("hold bit not written");
  chk_ctrl_write: assert property (ce && wr_ctrl |=>
    s_reg.settle_sel == $past(reg_wdata[`FLD_SETTLE_HI:`FLD_SETTLE_LO]) &&
    s_reg.tune_en == $past(reg_wdata[`BIT_TUNE_EN])) else $error("control not written");
  chk_trim_write: assert property (ce && wr_trim && !tune_active |=>
    oscillator_trim_code == $past(reg_wdata[`FLD_TRIM_HI:`FLD_TRIM_LO]))
    else $error("idle trim write lost");
  chk_status_ro: assert property (ce && reg_wr && !tune_active &&
    reg_addr == `OFS_TUNE_STATE |=> $stable(oscillator_tune_complete))
    else $error("status bit written");
  chk_state_read: assert property (ce && reg_rd && reg_addr == `OFS_TUNE_STATE |=>
    reg_rdata == {7'h00, $past(oscillator_tune_complete)}) else $error("status read wrong");
  chk_cal_read: assert property (ce && reg_rd && reg_addr == `OFS_CAL_RUN |=>
    reg_rdata == {7'h00, $past(cal_run)}) else $error("cal bit read wrong");
  chk_rdata_hold: assert property (ce && !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // Engine and calibration
  chk_cal_release: assert property (ce && wr_cal && reg_wdata[`BIT_CAL_RUN] |=>
    cal_run && !cal_logic_reset && !divider_reset) else $error("calibration not released");
  chk_abort_idle: assert property (ce && abort |=> !tune_active && synth_pll_hold)
    else $error("hold did not stop tuning");
  chk_done_steady: assert property (ce && !wr_hold && !tune_active |=>
    $stable(oscillator_tune_complete)) else $error("done moved without a run");
  chk_trim_clear: assert property (ce && tune_active && tmr_expired && !restart &&
    s_reg.fast_s2 |=> !oscillator_trim_code[$past(s_reg.bitpos)])
    else $error("trial bit kept while fast");
  chk_step_on: assert property (ce && tune_active && tmr_expired && !wr_hold &&
    s_reg.bitpos != 3'h0 |=> tune_active && s_reg.start &&
    s_reg.bitpos == $past(s_reg.bitpos) - 3'h1 && oscillator_trim_code[s_reg.bitpos])
    else $error("search step wrong");

  cov_full_run: cover property (ce && finish);
  cov_skip: cover property (ce && wr_hold && !reg_wdata[`BIT_HOLD] && !s_reg.tune_en);
  cov_cal_cycle: cover property (ce && wr_cal && !reg_wdata[`BIT_CAL_RUN] ##[1:20]
    ce && wr_cal && reg_wdata[`BIT_CAL_RUN]);
  cov_trim_reload: cover property (ce && wr_trim && !tune_active);
  cov_slow_settle: cover property (ce && restart && s_reg.settle_sel == 3'h2);
endmodule // pll_tune_ctrl

/* tb/test_pll_vco_tuning_and_cal_enable.sv */
module test_pll_vco_tuning_and_cal_enable;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic vco_fast_pin = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [6:0] trim;
  logic [6:0] target = 7'h00;
  logic hold, done, active, cal_run, cal_rst, div_rst;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n0, n1;

  pll_tune_ctrl pll_tune_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .vco_fast_pin(vco_fast_pin), .synth_pll_hold(hold), .oscillator_trim_code(trim),
    .oscillator_tune_complete(done), .tune_active(active), .cal_run(cal_run),
    .cal_logic_reset(cal_rst), .divider_reset(div_rst));

  initial forever #20 clk = ~clk;

  // Oscillator stand-in: too fast whenever trim is above the hidden target
  always @(negedge clk) vco_fast_pin <= trim > target;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rdata", reg_rdata, exp);
  endtask

  // Largest code not above the target, found MSB first
  function automatic logic [6:0] sar_expect(input logic [6:0] t);
    logic [6:0] r;
    r = 7'h00;
    for (int b = 6; b >= 0; b--) begin
      if ((r | (7'h01 << b)) <= t) r = r | (7'h01 << b);
    end
    return r;
  endfunction

  // Seven trial bits, each a wait of ceil(1000 ns / 40 ns) cycles scaled by the
  // select, plus two cycles to hand the next trial to the timer
  function automatic int run_cycles(input logic [2:0] sel);
    return 7 * ((25 << sel) + 2);
  endfunction

  task tune(input logic [2:0] sel, input logic [6:0] t, output int n);
    target = t;
    wr(8'h5c, 8'h01);
    chk("hold", {7'h00, hold}, 8'h01);
    wr(8'h5d, {1'b0, sel, 4'h1});
    wr(8'h5c, 8'h00);
    chk("active", {7'h00, active}, 8'h01);
    chk("done", {7'h00, done}, 8'h00);
    n = 0;
    // Trim is left alone until the flag rises
    while (done !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk("cycles", 16'(n), 16'(run_cycles(sel)));
    chk("trim", {1'b0, trim}, {1'b0, sar_expect(t)});
    rd(8'h59, {1'b0, sar_expect(t)});
    rd(8'h5e, 8'h01);
    $display("tune test sel %0d took %0d cycles", sel, n);
  endtask

  initial begin
    void'($urandom(76));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd(8'h5c, 8'h00);
    rd(8'h5d, 8'h40);
    rd(8'h5e, 8'h00);
    rd(8'h61, 8'h01);
    rd(8'h60, 8'h00);
    $display("reset test done");
    tune(3'h0, 7'h7f, n0);
    tune(3'h1, 7'($urandom_range(127)), n1);
    chk("settle", 8'(n1 > n0), 8'h01);
    tune(3'h2, 7'h00, n0);
    wr(8'h5c, 8'h01);
    chk("done", {7'h00, done}, 8'h00);
    wr(8'h5d, 8'h00);
    rd(8'h5d, 8'h00);
    wr(8'h5c, 8'h00);
    chk("done", {7'h00, done}, 8'h01);
    // Status is read-only; the write must not disturb the flag
    wr(8'h5e, 8'h00);
    chk("done", {7'h00, done}, 8'h01);
    target = 7'($urandom);
    wr(8'h59, {1'b0, target});
    rd(8'h59, {1'b0, target});
    chk("trim", {1'b0, trim}, {1'b0, target});
    wr(8'h61, 8'h00);
    chk("cal", {5'h00, cal_run, cal_rst, div_rst}, 8'h03);
    rd(8'h61, 8'h00);
    wr(8'h61, 8'h01);
    chk("cal", {5'h00, cal_run, cal_rst, div_rst}, 8'h04);
    // Low clock enable must swallow the write
    ce = 1'b0;
    wr(8'h5c, 8'h01);
    chk("frozen", {7'h00, hold}, 8'h00);
    ce = 1'b1;
    $display("register test done");
    finish_test();
  end
endmodule // test_pll_vco_tuning_and_cal_enable
